// ### common/physt_defines.svh
/*
  Constants of the management status and advertisement register bank:
  register addresses, bit positions, fixed and reset values, and the
  shape of a serial management frame.
  Assumes it is included by bare name from the design files.
*/
`ifndef PHYST_DEFINES_SVH
`define PHYST_DEFINES_SVH

// Register addresses on the serial management interface
`define PHYST_REG_MODE_STATUS 5'h01
`define PHYST_REG_ID_HIGH 5'h02
`define PHYST_REG_ID_LOW 5'h03
`define PHYST_REG_ADVERT 5'h04
`define PHYST_REG_PARTNER 5'h05
`define PHYST_REG_EXPANSION 5'h06

// Mode status: constant bits (capabilities, extended status, preamble)
`define PHYST_MODE_STATUS_FIXED 16'h79C9
`define PHYST_MS_AN_DONE 5
`define PHYST_MS_FAULT 4
`define PHYST_MS_LINK 2
`define PHYST_MS_JABBER 1

// Advertisement: reset value and writable bits (bit 14 stays zero)
`define PHYST_ADVERT_RESET 16'h01E1
`define PHYST_ADVERT_WMASK 16'hBFFF

// Expansion: constant bits (local next page able at bit 2)
`define PHYST_EXP_FIXED 16'h0004
`define PHYST_EXP_PDF 4
`define PHYST_EXP_PARTNER_NP 3
`define PHYST_EXP_PAGE_RX 1
`define PHYST_EXP_PARTNER_AN 0

// Frame shape: operation codes and bit counters
`define PHYST_OP_READ 2'h2
`define PHYST_OP_WRITE 2'h1
`define PHYST_HDR_LAST 5'h0C
`define PHYST_TURN_LAST 5'h01
`define PHYST_DATA_LAST 5'h0F

`endif

// ### common/physt_pkg.sv
/*
  Types of the management status and advertisement register bank:
  frame state machine and the packed state records of each module.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package physt_pkg;

  // Frame walker states, Gray coded along idle-head-turn-data
  typedef enum logic [1:0] {
    PHYST_S_IDLE = 2'h0,
    PHYST_S_HEAD = 2'h1,
    PHYST_S_TURN = 2'h3,
    PHYST_S_DATA = 2'h2
  } physt_state_t;

  // Whole state of the register bank top
  typedef struct packed {
    physt_state_t fsm;     // Frame position
    logic [4:0] cnt;       // Bit counter inside a frame field
    logic [15:0] shift;    // Header, write data or read data shifter
    logic mdc_prev;        // Management clock one cycle ago
    logic idle_seen;       // A one was seen on the data line
    logic is_read;         // Current frame is a read
    logic hit;             // Frame addresses this device
    logic [4:0] reg_addr;  // Register address of current frame
    logic mdio_oe;         // Data line drive enable
    logic mdio_o;          // Data line drive value
    logic [15:0] advert;   // Local ability advertisement
    logic [15:0] partner;  // Link partner base page
  } physt_regs_t;

  // Whole state of one latching status bit
  typedef struct packed {
    logic val;             // Latched value seen by reads
  } physt_latch_t;

endpackage : physt_pkg

`default_nettype wire

// ### logic/physt_latch.sv
/*
  One latching status bit: latches high or low on its condition and is
  released by a read of its register.
  Assumes the release pulse lasts one cycle and comes from the read.
*/
`default_nettype none

module physt_latch #(
  parameter bit LATCH_HIGH = 1'b1  // 1: latch high, 0: latch low
) (
  input wire logic clk_in,   // System clock
  input wire logic rst_in,   // Asynchronous reset, active high
  input wire logic cond_in,  // Live condition level
  input wire logic rel_in,   // Read release pulse
  output logic val_out       // Latched value
);

  physt_pkg::physt_latch_t s_q;  // Registered state
  physt_pkg::physt_latch_t s_d;  // Next state

  // Latch rule: the live condition always enters, so an event in the
  // very cycle of a read release is never lost
  always_comb begin
    s_d = s_q;
    if (LATCH_HIGH) begin
      s_d.val = cond_in | (s_q.val & ~rel_in);
    end else begin
      s_d.val = cond_in & (s_q.val | rel_in);
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '{val: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign val_out = s_q.val;

endmodule : physt_latch

`default_nettype wire

// ### logic/physt_regs.sv
/*
  Management register bank at addresses 1 to 6: mode status, the two
  identifier registers, local advertisement, link partner ability and
  expansion. Reached by a serial management frame slave.
  Assumes the management clock and data inputs are synchronous to
  CLK_IN and much slower than it, and that the negotiation engine
  drives the status levels and the partner page strobe.
*/
`include "physt_defines.svh"

`default_nettype none

module physt_regs #(
  parameter logic [15:0] OUI_HIGH = 16'h0A5A,  // Arbitrary value
  parameter logic [5:0] OUI_LOW = 6'h15,       // Arbitrary value
  parameter logic [5:0] MODEL_NUM = 6'h2A,     // Arbitrary value
  parameter logic [3:0] REVISION = 4'h3        // Arbitrary value
) (
  input wire logic CLK_IN,                 // System clock, 40 MHz
  input wire logic SYS_RST_IN,             // Async reset, active high
  input wire logic MDC_IN,                 // Management clock level
  input wire logic MDIO_IN,                // Management data in
  output logic MDIO_OUT,                   // Management data out
  output logic MDIO_OE_OUT,                // Drive enable for data
  input wire logic [4:0] PHY_ADDR_IN,      // Own station address
  input wire logic LINK_UP_IN,             // Live link level
  input wire logic REMOTE_FAULT_IN,        // Far-end fault seen
  input wire logic JABBER_IN,              // Jabber condition seen
  input wire logic AN_COMPLETE_IN,         // Negotiation complete
  input wire logic PARALLEL_FAULT_IN,      // Parallel detect fault
  input wire logic PAGE_RX_IN,             // New page received level
  input wire logic PARTNER_NP_ABLE_IN,     // Partner next page able
  input wire logic PARTNER_AN_ABLE_IN,     // Partner negotiates
  input wire logic [15:0] PARTNER_PAGE_IN, // Partner base page
  input wire logic PARTNER_PAGE_VALID_IN,  // Base page strobe
  output logic [15:0] ADVERT_OUT           // Advertisement register
);

  physt_pkg::physt_regs_t s_q;  // Registered state
  physt_pkg::physt_regs_t s_d;  // Next state

  logic mdc_rise;            // Rising edge of management clock
  logic rel_status;          // Read of mode status releases latches
  logic rel_exp;             // Read of expansion releases latches
  logic wr_commit;           // Advertisement write takes effect
  logic [15:0] wr_value;     // Full write word at commit
  logic [12:0] hdr;          // Header word at its last bit
  logic [15:0] rd_status;    // Mode status read value
  logic [15:0] rd_id_high;   // Identifier high read value
  logic [15:0] rd_id_low;    // Identifier low read value
  logic [15:0] rd_exp;       // Expansion read value
  logic [15:0] rdata;        // Selected read value
  logic link_lat;            // Latched link-up
  logic fault_lat;           // Latched far-end fault
  logic jab_lat;             // Latched jabber
  logic pdf_lat;             // Latched parallel detection fault
  logic page_lat;            // Latched page received

  // Latching status cells; each releases on a read of its register
  physt_latch #(.LATCH_HIGH(1'b0)) u_link (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .cond_in(LINK_UP_IN),
    .rel_in(rel_status),
    .val_out(link_lat)
  );

  physt_latch #(.LATCH_HIGH(1'b1)) u_fault (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .cond_in(REMOTE_FAULT_IN),
    .rel_in(rel_status),
    .val_out(fault_lat)
  );

  physt_latch #(.LATCH_HIGH(1'b1)) u_jabber (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .cond_in(JABBER_IN),
    .rel_in(rel_status),
    .val_out(jab_lat)
  );

  physt_latch #(.LATCH_HIGH(1'b1)) u_pdf (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .cond_in(PARALLEL_FAULT_IN),
    .rel_in(rel_exp),
    .val_out(pdf_lat)
  );

  physt_latch #(.LATCH_HIGH(1'b0)) u_page (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .cond_in(PAGE_RX_IN),
    .rel_in(rel_exp),
    .val_out(page_lat)
  );

  // Read values; constant bits come from the fixed patterns
  always_comb begin
    rd_status = `PHYST_MODE_STATUS_FIXED;
    rd_status[`PHYST_MS_AN_DONE] = AN_COMPLETE_IN;
    rd_status[`PHYST_MS_FAULT] = fault_lat;
    rd_status[`PHYST_MS_LINK] = link_lat;
    rd_status[`PHYST_MS_JABBER] = jab_lat;
    rd_id_high = OUI_HIGH;
    rd_id_low = {OUI_LOW, MODEL_NUM, REVISION};
    rd_exp = `PHYST_EXP_FIXED;
    rd_exp[`PHYST_EXP_PDF] = pdf_lat;
    rd_exp[`PHYST_EXP_PARTNER_NP] = PARTNER_NP_ABLE_IN;
    rd_exp[`PHYST_EXP_PAGE_RX] = page_lat;
    rd_exp[`PHYST_EXP_PARTNER_AN] = PARTNER_AN_ABLE_IN;
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    case (s_q.reg_addr)
      `PHYST_REG_MODE_STATUS: rdata = rd_status;
      `PHYST_REG_ID_HIGH: rdata = rd_id_high;
      `PHYST_REG_ID_LOW: rdata = rd_id_low;
      `PHYST_REG_ADVERT: rdata = s_q.advert;
      `PHYST_REG_PARTNER: rdata = s_q.partner;
      `PHYST_REG_EXPANSION: rdata = rd_exp;
      default: rdata = 16'h0000;
    endcase
  end

  assign mdc_rise = MDC_IN & ~s_q.mdc_prev;
  assign hdr = {s_q.shift[11:0], MDIO_IN};
  assign wr_value = {s_q.shift[14:0], MDIO_IN};

  // Frame walker: every field is sampled on a management clock rise;
  // the data line is also changed on a rise, giving the master a
  // whole management clock period of setup before its next sample
  always_comb begin
    s_d = s_q;
    rel_status = 1'b0;
    rel_exp = 1'b0;
    wr_commit = 1'b0;
    s_d.mdc_prev = MDC_IN;
    // Partner page is read-only to management, loaded by the engine
    if (PARTNER_PAGE_VALID_IN) begin
      s_d.partner = PARTNER_PAGE_IN;
    end
    if (mdc_rise) begin
      case (s_q.fsm)
        physt_pkg::PHYST_S_IDLE: begin
          // One idle one before the start zero is enough, so no
          // preamble is demanded
          if (!MDIO_IN && s_q.idle_seen) begin
            s_d.fsm = physt_pkg::PHYST_S_HEAD;
            s_d.cnt = 5'h00;
          end
          s_d.idle_seen = MDIO_IN;
        end
        physt_pkg::PHYST_S_HEAD: begin
          // Header shifts in most significant bit first
          s_d.shift = {s_q.shift[14:0], MDIO_IN};
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == `PHYST_HDR_LAST) begin
            // Foreign or malformed frames are walked, never answered
            s_d.is_read = (hdr[11:10] == `PHYST_OP_READ);
            s_d.hit = hdr[12] && (hdr[9:5] == PHY_ADDR_IN) &&
                      ((hdr[11:10] == `PHYST_OP_READ) ||
                       (hdr[11:10] == `PHYST_OP_WRITE));
            s_d.reg_addr = hdr[4:0];
            s_d.fsm = physt_pkg::PHYST_S_TURN;
            s_d.cnt = 5'h00;
          end
        end
        physt_pkg::PHYST_S_TURN: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt != `PHYST_TURN_LAST) begin
            // First turnaround bit: snapshot the register and drive
            // zero; the snapshot and the release are the same cycle
            if (s_q.hit && s_q.is_read) begin
              s_d.mdio_oe = 1'b1;
              s_d.mdio_o = 1'b0;
              s_d.shift = rdata;
              rel_status = (s_q.reg_addr == `PHYST_REG_MODE_STATUS);
              rel_exp = (s_q.reg_addr == `PHYST_REG_EXPANSION);
            end
          end else begin
            // Second turnaround bit: present data bit 15
            if (s_q.hit && s_q.is_read) begin
              s_d.mdio_o = s_q.shift[15];
              s_d.shift = {s_q.shift[14:0], 1'b0};
            end
            s_d.fsm = physt_pkg::PHYST_S_DATA;
            s_d.cnt = 5'h00;
          end
        end
        physt_pkg::PHYST_S_DATA: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.is_read) begin
            if (s_q.cnt == `PHYST_DATA_LAST) begin
              // Bit 0 has been sampled; let go of the line
              s_d.mdio_oe = 1'b0;
              s_d.mdio_o = 1'b0;
              s_d.fsm = physt_pkg::PHYST_S_IDLE;
              s_d.idle_seen = 1'b0;
            end else if (s_q.hit) begin
              s_d.mdio_o = s_q.shift[15];
              s_d.shift = {s_q.shift[14:0], 1'b0};
            end
          end else begin
            s_d.shift = wr_value;
            if (s_q.cnt == `PHYST_DATA_LAST) begin
              // Only the advertisement takes writes; bit 14 is kept
              // zero by the mask
              if (s_q.hit &&
                  (s_q.reg_addr == `PHYST_REG_ADVERT)) begin
                wr_commit = 1'b1;
                s_d.advert = wr_value &
                             `PHYST_ADVERT_WMASK;
              end
              s_d.fsm = physt_pkg::PHYST_S_IDLE;
              s_d.idle_seen = 1'b0;
            end
          end
        end
        default: begin
          s_d.fsm = physt_pkg::PHYST_S_IDLE;
          s_d.mdio_oe = 1'b0;
        end
      endcase
    end
  end

  // State register; advertisement resets to the TX/T abilities and
  // selector one, pause, next page and fault bits cleared
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      s_q <= '{fsm: physt_pkg::PHYST_S_IDLE,
               cnt: 5'h00,
               shift: 16'h0000,
               mdc_prev: 1'b0,
               idle_seen: 1'b0,
               is_read: 1'b0,
               hit: 1'b0,
               reg_addr: 5'h00,
               mdio_oe: 1'b0,
               mdio_o: 1'b0,
               advert: `PHYST_ADVERT_RESET,
               partner: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign MDIO_OUT = s_q.mdio_o;
  assign MDIO_OE_OUT = s_q.mdio_oe;
  assign ADVERT_OUT = s_q.advert;

  // Checks on the bank's own behaviour
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  a_link_holds_low:
    assert property ((!link_lat && !rel_status) |=> !link_lat)
    else $error("latched link rose without a read");

  a_fault_latches:
    assert property (REMOTE_FAULT_IN |=> rd_status[4] ##1
                     (rd_status[4] || $past(rel_status)))
    else $error("far-end fault not latched high");

  a_jabber_holds:
    assert property ((jab_lat && !rel_status) |=> jab_lat)
    else $error("jabber latch dropped without a read");

  a_status_caps:
    assert property (rd_status[15:9] == 7'h3C)
    else $error("capability bits wrong");

  a_ext_status:
    assert property (rd_status[8] && $stable(rd_status[8]))
    else $error("extended status bit not one");

  a_no_preamble:
    assert property ((s_q.fsm == physt_pkg::PHYST_S_IDLE && mdc_rise &&
                      s_q.idle_seen && !MDIO_IN)
                     |=> s_q.fsm == physt_pkg::PHYST_S_HEAD && rd_status[6])
    else $error("frame without preamble refused");

  a_an_status:
    assert property ($rose(AN_COMPLETE_IN) |-> rd_status[5] &&
                     rd_status[3] && rd_status[0])
    else $error("negotiation status bits wrong");

  a_ident_regs:
    assert property (rd_id_high == OUI_HIGH &&
                     rd_id_low[15:10] == OUI_LOW)
    else $error("identifier vendor bits wrong");

  a_model_rev:
    assert property (rd_id_low[9:4] == MODEL_NUM &&
                     rd_id_low[3:0] == REVISION)
    else $error("model or revision field wrong");

  a_advert_write:
    assert property (wr_commit |=>
                     ADVERT_OUT == ($past(wr_value) & 16'hBFFF))
    else $error("advertisement write not taken");

  a_advert_rsvd:
    assert property (!ADVERT_OUT[14])
    else $error("advertisement bit 14 set");

  a_partner_load:
    assert property (PARTNER_PAGE_VALID_IN |=>
                     s_q.partner == $past(PARTNER_PAGE_IN))
    else $error("partner page not captured");

  a_pdf_latches:
    assert property (PARALLEL_FAULT_IN |=> rd_exp[4])
    else $error("parallel detection fault not latched");

  a_exp_fixed:
    assert property (rd_exp[15:5] == 11'h000 && rd_exp[2])
    else $error("expansion fixed bits wrong");

  a_read_release:
    assert property ((rel_status && !JABBER_IN && !REMOTE_FAULT_IN)
                     |=> !jab_lat && !fault_lat)
    else $error("read did not release latches");

  a_turn_drive:
    assert property ((mdc_rise && s_q.fsm == physt_pkg::PHYST_S_TURN &&
                      s_q.cnt == 5'h00 && s_q.hit && s_q.is_read)
                     |=> MDIO_OE_OUT && !MDIO_OUT)
    else $error("turnaround zero not driven");

endmodule : physt_regs

`default_nettype wire

// ### testbench/physt_smi_master.sv
/*
  Station management controller model: sends serial management frames
  on MDC and the data line and collects read data.
  Assumes the device drive enable and value come straight from the
  register bank, and that the line has a pull-up.
*/
`default_nettype none

module physt_smi_master (
  input wire logic clk_in,      // Bench clock
  input wire logic dev_out_in,  // Device data drive value
  input wire logic dev_oe_in,   // Device drive enable
  output logic mdc_out,         // Management clock
  output logic mdio_out         // Resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;

  logic drv_en = 1'b0;   // Model drives the line
  logic drv_val = 1'b0;  // Model drive value

  // Pull-up wins when nobody drives, so a released line reads one
  assign mdio_out = dev_oe_in ? dev_out_in : (drv_en ? drv_val : 1'b1);

  initial mdc_out = 1'b0;  // Clock stands low outside frames

  // One bit: data set while MDC low, line sampled just before the rise
  task automatic one_bit(input logic en, input logic v, output logic s);
    @(negedge clk_in);
    mdc_out = 1'b0;
    drv_en = en;
    drv_val = v;
    repeat (3) @(negedge clk_in);
    s = mdio_out;
    mdc_out = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask : one_bit

  // Whole frame: one idle bit, no preamble, then 32 frame bits
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] regn, input logic [15:0] wdata,
                       output logic [15:0] rdata);
    logic [31:0] bits;
    logic s;
    logic rd;
    bits = {2'b01, op, phy, regn, 2'b10, wdata};
    rd = (op == 2'h2);
    one_bit(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      // Released from the turnaround on, so the device may answer
      one_bit(!(rd && i < 18), bits[i], s);
      if (i < 16) begin
        rdata[i] = s;  // Most significant bit first
      end
    end
    @(negedge clk_in);
    mdc_out = 1'b0;
    drv_en = 1'b0;
  endtask : frame
endmodule : physt_smi_master

`default_nettype wire

// ### testbench/test_physt_regs.sv
/*
  Self-checking bench of the management register bank: frames through
  the controller model, status levels driven from here.
  Assumes the register bank and the controller model are compiled first.
*/
`default_nettype none

module test_physt_regs;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] ADDR = 5'h05;      // Own station address
  localparam logic [15:0] OUI_H = 16'h0C3E; // Arbitrary value
  localparam logic [5:0] OUI_L = 6'h27;     // Arbitrary value
  localparam logic [5:0] MODEL = 6'h19;     // Arbitrary value
  localparam logic [3:0] REV = 4'h6;        // Arbitrary value
  localparam logic [15:0] ST = 16'h79C9;    // Status with link latch low

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mdc;
  logic mdio_w;
  logic dout;
  logic doe;
  logic link = 1'b0;
  logic rfault = 1'b0;
  logic jab = 1'b0;
  logic an_done = 1'b0;
  logic pdf = 1'b0;
  logic page_rx = 1'b0;
  logic np_able = 1'b0;
  logic an_able = 1'b0;
  logic [15:0] page = 16'h0000;
  logic page_vld = 1'b0;
  logic [15:0] advert;
  int num_errors = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;  // 40 MHz

  physt_regs #(.OUI_HIGH(OUI_H), .OUI_LOW(OUI_L), .MODEL_NUM(MODEL),
               .REVISION(REV)) i_dut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .MDC_IN(mdc), .MDIO_IN(mdio_w),
    .MDIO_OUT(dout), .MDIO_OE_OUT(doe), .PHY_ADDR_IN(ADDR),
    .LINK_UP_IN(link), .REMOTE_FAULT_IN(rfault), .JABBER_IN(jab),
    .AN_COMPLETE_IN(an_done), .PARALLEL_FAULT_IN(pdf),
    .PAGE_RX_IN(page_rx), .PARTNER_NP_ABLE_IN(np_able),
    .PARTNER_AN_ABLE_IN(an_able), .PARTNER_PAGE_IN(page),
    .PARTNER_PAGE_VALID_IN(page_vld), .ADVERT_OUT(advert));

  physt_smi_master i_smi (
    .clk_in(clk), .dev_out_in(dout), .dev_oe_in(doe), .mdc_out(mdc),
    .mdio_out(mdio_w));

  // Verdict, also reached when the watchdog runs out
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk16

  task automatic rd_chk(input logic [4:0] phy, input logic [4:0] r,
                        input logic [15:0] exp, input string what);
    logic [15:0] d;
    i_smi.frame(2'h2, phy, r, 16'h0000, d);
    chk16(d, exp, what);
  endtask : rd_chk

  task automatic wr(input logic [1:0] op, input logic [4:0] phy,
                    input logic [4:0] r, input logic [15:0] v);
    logic [15:0] d;
    i_smi.frame(op, phy, r, v, d);
  endtask : wr

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("mismatch at %0t: run timed out", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk16(advert, 16'h01E1, "advert reset");
    chk16({15'h0000, doe}, 16'h0000, "idle drive");
    rd_chk(ADDR, 5'h04, 16'h01E1, "reg4 reset");
    link = 1'b1;
    rd_chk(ADDR, 5'h01, ST, "status first");
    rd_chk(ADDR, 5'h01, ST | 16'h0004, "link up");
    // Short link drop, recovered before the read
    @(negedge clk);
    link = 1'b0;
    repeat (2) @(negedge clk);
    link = 1'b1;
    rd_chk(ADDR, 5'h01, ST, "link drop held");
    rd_chk(ADDR, 5'h01, ST | 16'h0004, "link back");
    @(negedge clk);
    rfault = 1'b1;
    jab = 1'b1;
    an_done = 1'b1;
    @(negedge clk);
    rfault = 1'b0;
    jab = 1'b0;
    rd_chk(ADDR, 5'h01, ST | 16'h0036, "events");
    rd_chk(ADDR, 5'h01, ST | 16'h0024, "events freed");
    rd_chk(ADDR, 5'h02, OUI_H, "id high");
    rd_chk(ADDR, 5'h03, {OUI_L, MODEL, REV}, "id low");
    wr(2'h1, ADDR, 5'h04, 16'hFFFF);
    chk16(advert, 16'hBFFF, "advert ones");
    rd_chk(ADDR, 5'h04, 16'hBFFF, "reg4 ones");
    wr(2'h1, ADDR, 5'h04, 16'h2C00);
    chk16(advert, 16'h2C00, "advert pause");
    // Refused frames: foreign station, bad codes, read-only places
    wr(2'h1, ADDR ^ 5'h01, 5'h04, 16'h0000);
    wr(2'h0, ADDR, 5'h04, 16'h0000);
    wr(2'h3, ADDR, 5'h04, 16'h0000);
    wr(2'h1, ADDR, 5'h01, 16'h0000);
    wr(2'h1, ADDR, 5'h05, 16'hFFFF);
    chk16(advert, 16'h2C00, "advert kept");
    rd_chk(ADDR, 5'h05, 16'h0000, "partner read-only");
    rd_chk(ADDR ^ 5'h01, 5'h04, 16'hFFFF, "foreign undriven");
    rd_chk(ADDR, 5'h07, 16'h0000, "unmapped read");
    @(negedge clk);
    page = 16'hE5A1;
    page_vld = 1'b1;
    @(negedge clk);
    page_vld = 1'b0;
    page = 16'h0000;
    rd_chk(ADDR, 5'h05, 16'hE5A1, "partner page");
    np_able = 1'b1;
    an_able = 1'b1;
    page_rx = 1'b1;
    pdf = 1'b1;
    @(negedge clk);
    pdf = 1'b0;
    rd_chk(ADDR, 5'h06, 16'h001D, "exp held");
    rd_chk(ADDR, 5'h06, 16'h000F, "expansion freed");
    @(negedge clk);
    page_rx = 1'b0;
    @(negedge clk);
    page_rx = 1'b1;
    rd_chk(ADDR, 5'h06, 16'h000D, "page rx low held");
    // Second reset in mid-run
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk16(advert, 16'h01E1, "advert re-reset");
    rd_chk(ADDR, 5'h05, 16'h0000, "partner cleared");
    tally_and_finish();
  end
endmodule : test_physt_regs

`default_nettype wire
